// *** common/adcrs_defs.svh ***
/*
  Constants of the converter result and status flag block: register offsets,
  field positions, reset values and the channel count.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef ADCRS_DEFS_SVH
`define ADCRS_DEFS_SVH

`define ADCRS_NUM_CH        8
`define ADCRS_DATA_W        10
`define ADCRS_ADDR_W        8

`define ADCRS_OFF_CTRL      8'h00
`define ADCRS_OFF_MODE      8'h04
`define ADCRS_OFF_CHEN      8'h10
`define ADCRS_OFF_CHDIS     8'h14
`define ADCRS_OFF_CHSTAT    8'h18
`define ADCRS_OFF_STATUS    8'h1C
`define ADCRS_OFF_LAST      8'h20
`define ADCRS_OFF_IRQMASK   8'h24
`define ADCRS_OFF_IRQSTAT   8'h28
`define ADCRS_OFF_CHRES0    8'h30

`define ADCRS_CTRL_START    0
`define ADCRS_MODE_SLEEP    0

`define ADCRS_ST_DONE_LSB   0
`define ADCRS_ST_OVR_LSB    8
`define ADCRS_ST_READY      16
`define ADCRS_ST_GOVR       17
`define ADCRS_ST_SLEEPING   18

`define ADCRS_LAST_CH_LSB   12

`define ADCRS_IRQ_READY     0
`define ADCRS_IRQ_GOVR      1
`define ADCRS_IRQ_OVR       2

`define ADCRS_RST_WORD      32'h0000_0000
`define ADCRS_RESP_OKAY     2'h0
`define ADCRS_RESP_SLVERR   2'h2

`endif

// *** common/adcrs_pkg.sv ***
/*
  Types of the converter result and status flag block.
  Assumes the constants header is on the include path.
*/
`include "adcrs_defs.svh"

package adcrs_pkg;

  typedef struct packed {
    logic                                 valid;
    logic [$clog2(`ADCRS_NUM_CH)-1:0]     channel;
    logic [`ADCRS_DATA_W-1:0]             data;
  } adcrs_conv_type;

  typedef enum logic [1:0] {
    ADCRS_IDLE  = 2'h0,
    ADCRS_RESP  = 2'h1
  } adcrs_bus_type;

endpackage

// *** hw/adcrs_flag_core.sv ***
/*
  Per-channel done and overrun flags with their set and clear arbitration.
  Assumes read strobes and conversion ends are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ns

`include "adcrs_defs.svh"

module adcrs_flag_core #(
  parameter int NUM_CH = `ADCRS_NUM_CH
) (
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Events.
  input  wire logic              convEnd,
  input  wire logic [NUM_CH-1:0] convSel,
  input  wire logic              lastRead,
  input  wire logic [NUM_CH-1:0] chanRead,
  input  wire logic              statusRead,
  // Flags.
  output logic      [NUM_CH-1:0] doneFlag,
  output logic      [NUM_CH-1:0] channel_overrun_flag
);

  logic [NUM_CH-1:0] setDone;
  logic [NUM_CH-1:0] clrDone;

  // Only the channel whose register is read is cleared; a last-result read
  // clears every done flag not being set in the same cycle.
  assign setDone = convEnd ? convSel : '0;
  assign clrDone = lastRead ? {NUM_CH{1'b1}} : chanRead; // RULE3 RULE4

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      doneFlag <= '0;
    else
      doneFlag <= setDone | (doneFlag & ~clrDone); // RULE3 RULE4
  end

  // A status read clears overrun except where a new overrun lands that cycle.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      channel_overrun_flag <= '0;
    else
      channel_overrun_flag <= (setDone & doneFlag)
                              | (channel_overrun_flag & ~{NUM_CH{statusRead}}); // RULE5 RULE6
  end

endmodule // adcrs_flag_core

// *** hw/adcrs_result_status.sv ***
/*
  Result and status flag logic of the converter, with an AXI4-Lite slave.
  Assumes the conversion core delivers one-cycle result strobes on core_clk.
*/
// Overview of operation
// RULE1: Ready flag clears only on a last-result read, never on channel reads.
// RULE2: Every conversion stores channel and last results and sets ready, always.
// RULE3: Channel done clears on its own result read or a last-result read.
// RULE4: A channel read clears only that channel's done flag.
// RULE5: Conversion end with done still set raises that channel's overrun.
// RULE6: Status read clears channel overrun unless a new one occurs on that channel that cycle.
// RULE7: Conversion end with ready still set raises global overrun, despite reads.
// RULE8: Status read clears global overrun unless a new one occurs that cycle.
// RULE9: Channel reads never suppress setting ready or global overrun.
// RULE10: Software ignores done flags of channels it has disabled.
// RULE11: Sleep takes effect after a conversion completes; start one after setting sleep.
`timescale 1ns/1ns

`include "adcrs_defs.svh"

module adcrs_result_status #(
  parameter int NUM_CH = `ADCRS_NUM_CH,
  parameter int DATA_W = `ADCRS_DATA_W
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // AXI4-Lite write address and data.
  input  wire logic [`ADCRS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [`ADCRS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Conversion core.
  input  wire logic                      convEnd,
  input  wire logic [$clog2(NUM_CH)-1:0] convChannel,
  input  wire logic [DATA_W-1:0]         convData,
  output logic                           convStart,
  output logic [NUM_CH-1:0]              chanEnable,
  output logic                           sleepActive,
  // Interrupt.
  output logic                           irq
);

  localparam int CW = $clog2(NUM_CH);

  // Register state.
  logic [DATA_W-1:0]  channel_result_reg [NUM_CH];
  logic [DATA_W-1:0]  last_result_reg;
  logic [CW-1:0]      lastChannel;
  logic               global_result_ready_flag;
  logic               global_overrun_flag;
  logic               sleepReq;
  logic [2:0]         irqStat;
  logic [2:0]         irqMask;
  logic [NUM_CH-1:0]  doneFlag;
  logic [NUM_CH-1:0]  channel_overrun_flag;

  // Bus state.
  logic                    awHeld;
  logic                    wHeld;
  logic [`ADCRS_ADDR_W-1:0] awAddr;
  logic [31:0]             wData;
  logic [3:0]              wStrb;
  logic                    doWrite;
  logic                    readTake;
  logic                    lastRead;
  logic                    statusRead;
  logic [NUM_CH-1:0]       chanRead;
  logic [NUM_CH-1:0]       convSel;
  logic                    newGovr;
  logic [31:0]             next_rdata;
  logic                    next_rerr;
  logic [2:0]              irqEvent;
  adcrs_pkg::adcrs_conv_type conv;

  function automatic logic isChanRes(input logic [`ADCRS_ADDR_W-1:0] a);
    return a >= `ADCRS_OFF_CHRES0
           && a < `ADCRS_OFF_CHRES0 + 8'(4 * NUM_CH) && a[1:0] == 2'h0;
  endfunction

  function automatic logic [CW-1:0] chanIdx(input logic [`ADCRS_ADDR_W-1:0] a);
    logic [`ADCRS_ADDR_W-1:0] d;
    d = a - `ADCRS_OFF_CHRES0;
    return d[CW+1:2];
  endfunction

  assign conv = '{valid: convEnd, channel: convChannel, data: convData};

  // Write channel: address and data are accepted independently.
  assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
  assign readTake = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCRS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == `ADCRS_OFF_CTRL || awAddr == `ADCRS_OFF_MODE
                         || awAddr == `ADCRS_OFF_CHEN || awAddr == `ADCRS_OFF_CHDIS
                         || awAddr == `ADCRS_OFF_IRQMASK || awAddr == `ADCRS_OFF_IRQSTAT)
                        ? `ADCRS_RESP_OKAY : `ADCRS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software-written control: start pulse, sleep request, channel enables, mask.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      convStart  <= 1'b0;
      sleepReq   <= 1'b0;
      chanEnable <= '0;
      irqMask    <= '0;
    end
    else
    begin
      convStart <= doWrite && wStrb[0] && awAddr == `ADCRS_OFF_CTRL
                   && wData[`ADCRS_CTRL_START];
      if (doWrite && wStrb[0] && awAddr == `ADCRS_OFF_MODE)
        sleepReq <= wData[`ADCRS_MODE_SLEEP];
      if (doWrite && awAddr == `ADCRS_OFF_CHEN)
        chanEnable <= chanEnable | wData[NUM_CH-1:0];
      else if (doWrite && awAddr == `ADCRS_OFF_CHDIS)
        chanEnable <= chanEnable & ~wData[NUM_CH-1:0];
      if (doWrite && wStrb[0] && awAddr == `ADCRS_OFF_IRQMASK)
        irqMask <= wData[2:0];
    end
  end

  // Sleep is entered only when a conversion completes, left at once on clear.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sleepActive <= 1'b0;
    else if (!sleepReq)
      sleepActive <= 1'b0;
    else if (conv.valid)
      sleepActive <= 1'b1; // RULE11
  end

  // Read side effects are taken at the edge where the address is accepted.
  always_comb
  begin
    lastRead   = readTake && s_axi_araddr == `ADCRS_OFF_LAST;
    statusRead = readTake && s_axi_araddr == `ADCRS_OFF_STATUS;
    chanRead   = '0;
    if (readTake && isChanRes(s_axi_araddr))
      chanRead[chanIdx(s_axi_araddr)] = 1'b1;
    convSel = '0;
    convSel[conv.channel] = 1'b1;
  end

  // Results are stored regardless of any channel being disabled meanwhile.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_CH; i++)
        channel_result_reg[i] <= '0;
      last_result_reg <= '0;
      lastChannel     <= '0;
    end
    else if (conv.valid)
    begin
      channel_result_reg[conv.channel] <= conv.data; // RULE2
      last_result_reg                  <= conv.data; // RULE2
      lastChannel                      <= conv.channel;
    end
  end

  // Ready: set wins over the last-result read; channel reads do not touch it.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      global_result_ready_flag <= 1'b0;
    else if (conv.valid)
      global_result_ready_flag <= 1'b1; // RULE2 RULE9
    else if (lastRead)
      global_result_ready_flag <= 1'b0; // RULE1
  end

  assign newGovr = conv.valid && global_result_ready_flag; // RULE7 RULE9

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      global_overrun_flag <= 1'b0;
    else if (newGovr)
      global_overrun_flag <= 1'b1; // RULE7
    else if (statusRead)
      global_overrun_flag <= 1'b0; // RULE8
  end

  adcrs_flag_core #(
    .NUM_CH (NUM_CH)
  ) u_flags (
    .core_clk             (core_clk),
    .rstn                 (rstn),
    .convEnd              (conv.valid),
    .convSel              (convSel),
    .lastRead             (lastRead),
    .chanRead             (chanRead),
    .statusRead           (statusRead),
    .doneFlag             (doneFlag),
    .channel_overrun_flag (channel_overrun_flag)
  );

  // Sticky interrupt status: ready, global overrun, any channel overrun.
  assign irqEvent = {conv.valid && |(convSel & doneFlag), newGovr, conv.valid};

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irqStat <= '0;
    else if (doWrite && wStrb[0] && awAddr == `ADCRS_OFF_IRQSTAT)
      irqStat <= irqEvent | (irqStat & ~wData[2:0]);
    else
      irqStat <= irqEvent | irqStat;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irqStat & irqMask);
  end

  // Read data mux; the value returned reflects flags before the read clears them.
  always_comb
  begin
    next_rdata = `ADCRS_RST_WORD;
    next_rerr  = 1'b0;
    if (isChanRes(s_axi_araddr))
      next_rdata[DATA_W-1:0] = channel_result_reg[chanIdx(s_axi_araddr)];
    else
      unique case (s_axi_araddr)
        `ADCRS_OFF_CTRL:    next_rdata = `ADCRS_RST_WORD;
        `ADCRS_OFF_MODE:    next_rdata[`ADCRS_MODE_SLEEP] = sleepReq;
        `ADCRS_OFF_CHEN,
        `ADCRS_OFF_CHDIS:   next_rdata = `ADCRS_RST_WORD;
        `ADCRS_OFF_CHSTAT:  next_rdata[NUM_CH-1:0] = chanEnable;
        `ADCRS_OFF_STATUS:
        begin
          next_rdata[`ADCRS_ST_DONE_LSB +: NUM_CH] = doneFlag;
          next_rdata[`ADCRS_ST_OVR_LSB +: NUM_CH]  = channel_overrun_flag;
          next_rdata[`ADCRS_ST_READY]              = global_result_ready_flag;
          next_rdata[`ADCRS_ST_GOVR]               = global_overrun_flag;
          next_rdata[`ADCRS_ST_SLEEPING]           = sleepActive;
        end
        `ADCRS_OFF_LAST:
        begin
          next_rdata[DATA_W-1:0]                = last_result_reg;
          next_rdata[`ADCRS_LAST_CH_LSB +: CW]  = lastChannel;
        end
        `ADCRS_OFF_IRQMASK: next_rdata[2:0] = irqMask;
        `ADCRS_OFF_IRQSTAT: next_rdata[2:0] = irqStat;
        default:            next_rerr = 1'b1;
      endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `ADCRS_RESP_OKAY;
    end
    else if (readTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rerr ? `ADCRS_RESP_SLVERR : `ADCRS_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // adcrs_result_status

// *** tb/adcrs_monitor.sv ***
/* Bus handshake, start pulse and sleep checks on the result and status block.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ns
module adcrs_monitor (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rstn,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Conversion core.
  input wire logic        convEnd,
  input wire logic        convStart,
  input wire logic        sleepActive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("start is not a single pulse");
  a_sleep_cause: assert property ($rose(sleepActive) |-> $past(convEnd))
    else $error("sleep entered without a conversion end");
endmodule // adcrs_monitor

bind adcrs_result_status adcrs_monitor mon (.core_clk(core_clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .convEnd(convEnd),
  .convStart(convStart), .sleepActive(sleepActive));

// *** tb/adcrs_result_status_bench.sv ***
/* Self-checking bench of the converter result and status block.
   Assumes the header, package, design and monitor are compiled first. */
`timescale 1ns/1ns
module adcrs_result_status_bench;
  logic        core_clk, rstn, awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady, convEnd, convStart, sleepActive, irq;
  logic [7:0]  awAddr, arAddr, chanEnable, mDone, mOvr, mEn;
  logic [31:0] wData, rData, r, seed;
  logic [1:0]  bResp, rResp;
  logic [2:0]  convChannel, mLastCh, mIrq;
  logic [9:0]  convData, mLast;
  logic [9:0]  mRes [8];
  logic        mRdy, mGovr, mSleep, mMode;
  int          n_errors, tests_run, nStart;

  adcrs_result_status uut (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .convEnd(convEnd), .convChannel(convChannel), .convData(convData),
    .convStart(convStart), .chanEnable(chanEnable), .sleepActive(sleepActive), .irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (convStart === 1'b1) nStart++;

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] ex(logic [7:0] a);
    if (a == 8'h18) return {24'h0, mEn};
    if (a == 8'h1C) return {13'h0, mSleep, mGovr, mRdy, mOvr, mDone};
    if (a == 8'h20) return {17'h0, mLastCh, 2'h0, mLast};
    if (a == 8'h28) return {29'h0, mIrq};
    if (a >= 8'h30 && a < 8'h50) return {22'h0, mRes[3'((a - 8'h30) >> 2)]};
    return 32'h0;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Applies one cycle of read clears and a conversion end; sets win over clears.
  task automatic upd(logic [7:0] a, logic ce, logic [2:0] c, logic [9:0] d);
    logic [7:0] dn;
    logic [7:0] ov;
    logic       rd;
    logic       gv;
    ov = (a == 8'h1C) ? 8'h0 : mOvr;
    gv = (a == 8'h1C) ? 1'b0 : mGovr;
    dn = (a == 8'h20) ? 8'h0 : mDone;
    rd = (a == 8'h20) ? 1'b0 : mRdy;
    if (a >= 8'h30 && a < 8'h50) dn[3'((a - 8'h30) >> 2)] = 1'b0;
    if (ce)
    begin
      if (mDone[c]) ov[c] = 1'b1;
      if (mDone[c]) mIrq[2] = 1'b1;
      if (mRdy) gv = 1'b1;
      if (mRdy) mIrq[1] = 1'b1;
      dn[c] = 1'b1;
      rd = 1'b1;
      mRes[c] = d;
      mLast = d;
      mLastCh = c;
      mIrq[0] = 1'b1;
      if (mMode) mSleep = 1'b1;
    end
    {mDone, mOvr, mRdy, mGovr} = {dn, ov, rd, gv};
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end
    while (!bValid);
    bReady <= 1'b0;
    chk("write resp", 32'(bResp), 32'(er));
  endtask

  // Reads one register, with an optional conversion end at the same edge.
  task automatic op(logic [7:0] a, logic ce, logic [2:0] c, logic [9:0] d);
    logic [31:0] e;
    e = ex(a);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    convEnd <= ce;
    convChannel <= c;
    convData <= d;
    do @(posedge core_clk); while (!arReady);
    arValid <= 1'b0;
    convEnd <= 1'b0;
    do @(posedge core_clk); while (!rValid);
    rReady <= 1'b0;
    upd(a, ce, c, d);
    chk("read data", rData, e);
    if (a == 8'h1C) chk("enabled done", 32'(rData[7:0] & mEn), 32'(e[7:0] & mEn));
    chk("read resp", 32'(rResp), (a == 8'h2C) ? 32'h2 : 32'h0);
  endtask

  task automatic cv(logic [2:0] c, logic [9:0] d);
    @(posedge core_clk);
    convEnd <= 1'b1;
    convChannel <= c;
    convData <= d;
    @(posedge core_clk);
    convEnd <= 1'b0;
    upd(8'hFF, 1'b1, c, d);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results();
  end

  initial
  begin
    {rstn, awValid, wValid, bReady, arValid, rReady, convEnd} = '0;
    {awAddr, arAddr, wData, convChannel, convData} = '0;
    {mDone, mOvr, mEn, mLastCh, mIrq, mLast, mRdy, mGovr, mSleep, mMode} = '0;
    for (int i = 0; i < 8; i++) mRes[i] = 10'h0;
    seed = 32'h2474;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    op(8'h1C, 1'b0, 3'h0, 10'h0);
    wr(8'h10, 32'hFF, 2'h0);
    wr(8'h14, 32'h0F, 2'h0);
    mEn = 8'hF0;
    op(8'h18, 1'b0, 3'h0, 10'h0);
    chk("enables", 32'(chanEnable), 32'hF0);
    wr(8'h1C, 32'h1, 2'h2);
    wr(8'h2C, 32'h1, 2'h2);
    op(8'h2C, 1'b0, 3'h0, 10'h0);
    wr(8'h04, 32'h1, 2'h0);
    mMode = 1'b1;
    repeat (2) @(posedge core_clk);
    chk("sleep idle", 32'(sleepActive), 32'h0);
    wr(8'h00, 32'h1, 2'h0);
    cv(3'h2, 10'h3FF);
    repeat (2) @(posedge core_clk);
    chk("start count", nStart, 1);
    chk("sleep after end", 32'(sleepActive), 32'h1);
    op(8'h1C, 1'b0, 3'h0, 10'h0);
    wr(8'h04, 32'h0, 2'h0);
    {mMode, mSleep} = 2'b00;
    wr(8'h28, 32'h7, 2'h0);
    mIrq = 3'h0;
    wr(8'h24, 32'h1, 2'h0);
    repeat (3) @(posedge core_clk);
    chk("irq clear", 32'(irq), 32'h0);
    cv(3'h5, 10'h155);
    repeat (3) @(posedge core_clk);
    chk("irq raised", 32'(irq), 32'h1);
    op(8'h28, 1'b0, 3'h0, 10'h0);
    wr(8'h24, 32'h0, 2'h0);
    repeat (3) @(posedge core_clk);
    chk("irq masked", 32'(irq), 32'h0);
    for (int i = 0; i < 120; i++)
    begin
      r = xs(seed);
      seed = r;
      case (r[9:8])
        2'h0: op(8'h1C, r[10], r[13:11], r[23:14]);
        2'h1: op(8'h20, r[10], r[13:11], r[23:14]);
        2'h2: op(8'h30 + {3'h0, r[2:0], 2'h0}, r[10], r[13:11], r[23:14]);
        default: cv(r[13:11], r[23:14]);
      endcase
    end
    op(8'h1C, 1'b0, 3'h0, 10'h0);
    results();
  end
endmodule // adcrs_result_status_bench
